// File: ata_regs_pkg.sv
/*
 * Constants and carrier types for the task-file status, device control,
 * drive address and SMART sub-command block.
 * Assumes a single 50 MHz device clock and an active-low async reset.
 */
package ata_regs_pkg;

    // ======================================================================
    // Register offsets
    localparam logic [3:0] OFFSET_ERROR_FEATURE = 4'h1;
    localparam logic [3:0] OFFSET_SECTOR_COUNT  = 4'h2;
    localparam logic [3:0] OFFSET_SECTOR_NUMBER = 4'h3;
    localparam logic [3:0] OFFSET_CYL_LOW       = 4'h4;
    localparam logic [3:0] OFFSET_CYL_HIGH      = 4'h5;
    localparam logic [3:0] OFFSET_DRIVE_HEAD    = 4'h6;
    localparam logic [3:0] OFFSET_STATUS        = 4'h7;
    localparam logic [3:0] OFFSET_ALT_CONTROL   = 4'he;
    localparam logic [3:0] OFFSET_DRIVE_ADDRESS = 4'hf;

    // ======================================================================
    // Field positions
    localparam int CTRL_SOFT_RESET_BIT = 2;
    localparam int CTRL_INT_ENABLE_N_BIT = 1;
    localparam int ERROR_ABORT_BIT = 2;
    localparam int DRIVE_HEAD_DRV_BIT = 4;

    // ======================================================================
    // Reset values and codes
    localparam logic [7:0] ERROR_RESET     = 8'h00;
    localparam logic [7:0] ERROR_ABORT     = 8'h04;
    localparam logic [7:0] DRIVE_HEAD_RESET = 8'ha0;
    localparam logic [7:0] SMART_READ_DATA   = 8'hd0;
    localparam logic [7:0] SMART_READ_THRESH = 8'hd1;
    localparam logic [7:0] SMART_AUTOSAVE    = 8'hd2;
    localparam logic [7:0] SMART_ENABLE      = 8'hd8;
    localparam logic [7:0] SMART_DISABLE     = 8'hd9;
    localparam logic [7:0] SMART_RETURN_STAT = 8'hda;
    localparam logic [7:0] SIGNATURE_LOW     = 8'h4f;
    localparam logic [7:0] SIGNATURE_HIGH    = 8'hc2;
    localparam logic [7:0] AUTOSAVE_COUNT_A  = 8'h00;
    localparam logic [7:0] AUTOSAVE_COUNT_B  = 8'hf1;

    // ======================================================================
    // Carrier types
    typedef struct packed {
        logic       readStrobe;
        logic       writeStrobe;
        logic [3:0] address;
        logic [7:0] data;
    } hostBus_type;

    typedef struct packed {
        logic busy;
        logic ready;
        logic writeFault;
        logic transferRequest;
        logic correctedError;
        logic writeInProgress;
        logic drive0Active;
        logic drive1Active;
    } coreStatus_type;

endpackage

// File: ata_status_control_smart.sv
/*
 * Task-file status, alternate status, device control and drive address
 * registers with SMART sub-command decode and interrupt request.
 * Assumes host strobes and bus arrive asynchronously on pins, and that the
 * media core runs on ref_clk and keeps the SMART state in non-volatile store.
 */
`timescale 1ns/1ps
`default_nettype none

module ata_status_control_smart #(
    parameter logic [7:0] SMART_COMMAND_CODE = 8'hb0
) (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           nrst,
    // Host task-file pins
    input  wire ata_regs_pkg::hostBus_type      hostBus,
    output logic [7:0]                          hostDataOut,
    output logic                                hostDataOe,
    output logic                                interruptRequest,
    // Media core
    input  wire ata_regs_pkg::coreStatus_type   coreStatus,
    input  wire logic                           commandDone,
    input  wire logic                           commandFailed,
    input  wire logic [7:0]                     commandErrorCode,
    output logic                                commandStart,
    output logic [7:0]                          commandCode,
    output logic [7:0]                          featureCode,
    output logic                                softReset,
    // Non-volatile SMART state
    input  wire logic                           smartStored,
    output logic                                smartEnabled,
    output logic                                smartStoreWrite,
    output logic                                smartStoreValue
);

    // ======================================================================
    // Pin synchroniser
    ata_regs_pkg::hostBus_type syncFirst;
    ata_regs_pkg::hostBus_type syncSecond;
    logic                      readSeen;
    logic                      writeSeen;
    logic                      readPulse;
    logic                      writePulse;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncFirst  <= '0;
            syncSecond <= '0;
            readSeen   <= 1'b0;
            writeSeen  <= 1'b0;
        end else begin
            syncFirst  <= hostBus;
            syncSecond <= syncFirst;
            readSeen   <= syncSecond.readStrobe;
            writeSeen  <= syncSecond.writeStrobe;
        end
    end

    assign readPulse  = syncSecond.readStrobe && !readSeen;
    assign writePulse = syncSecond.writeStrobe && !writeSeen;

    // ======================================================================
    // Task-file registers written by the host
    logic [7:0] feature;
    logic [7:0] sectorCount;
    logic [7:0] sectorNumber;
    logic [7:0] cylLow;
    logic [7:0] cylHigh;
    logic [7:0] driveHead;
    logic       interruptEnableN;
    logic       smartCommandWrite;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            feature      <= '0;
            sectorCount  <= '0;
            sectorNumber <= '0;
            cylLow       <= '0;
            cylHigh      <= '0;
            driveHead    <= ata_regs_pkg::DRIVE_HEAD_RESET;
        end else if (writePulse && !coreStatus.busy) begin
            if (syncSecond.address == ata_regs_pkg::OFFSET_ERROR_FEATURE) begin
                feature <= syncSecond.data;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_SECTOR_COUNT) begin
                sectorCount <= syncSecond.data;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_SECTOR_NUMBER) begin
                sectorNumber <= syncSecond.data;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_CYL_LOW) begin
                cylLow <= syncSecond.data;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_CYL_HIGH) begin
                cylHigh <= syncSecond.data;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_DRIVE_HEAD) begin
                driveHead <= syncSecond.data;
            end
        end
    end

    // Device control: only soft reset and interrupt enable are kept
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            softReset        <= 1'b0;
            interruptEnableN <= 1'b0;
        end else if (writePulse && syncSecond.address == ata_regs_pkg::OFFSET_ALT_CONTROL) begin
            softReset        <= syncSecond.data[ata_regs_pkg::CTRL_SOFT_RESET_BIT];
            interruptEnableN <= syncSecond.data[ata_regs_pkg::CTRL_INT_ENABLE_N_BIT];
        end else if (softReset) begin
            interruptEnableN <= 1'b0;
        end
    end

    assign smartCommandWrite = writePulse && !coreStatus.busy && !softReset
                               && syncSecond.address == ata_regs_pkg::OFFSET_STATUS
                               && syncSecond.data == SMART_COMMAND_CODE;

    // ======================================================================
    // SMART sub-command decode
    logic signatureOk;
    logic localDone;
    logic localAbort;
    logic forwardSmart;

    assign signatureOk = cylLow == ata_regs_pkg::SIGNATURE_LOW
                         && cylHigh == ata_regs_pkg::SIGNATURE_HIGH;

    always_comb begin
        localDone    = 1'b0;
        localAbort   = 1'b0;
        forwardSmart = 1'b0;
        if (smartCommandWrite) begin
            case (feature)
                ata_regs_pkg::SMART_ENABLE,
                ata_regs_pkg::SMART_DISABLE: begin
                    localDone  = signatureOk;
                    localAbort = !signatureOk;
                end
                ata_regs_pkg::SMART_AUTOSAVE: begin
                    localDone = signatureOk && smartEnabled
                                && (sectorCount == ata_regs_pkg::AUTOSAVE_COUNT_A
                                    || sectorCount == ata_regs_pkg::AUTOSAVE_COUNT_B);
                    localAbort = !localDone;
                end
                ata_regs_pkg::SMART_READ_DATA,
                ata_regs_pkg::SMART_READ_THRESH,
                ata_regs_pkg::SMART_RETURN_STAT: begin
                    forwardSmart = smartEnabled;
                    localAbort   = !smartEnabled;
                end
                default: begin
                    localAbort = 1'b1;
                end
            endcase
        end
    end

    // SMART state loaded from store after reset, written back on each accepted enable or disable
    logic smartLoaded;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            smartEnabled    <= 1'b0;
            smartLoaded     <= 1'b0;
            smartStoreWrite <= 1'b0;
            smartStoreValue <= 1'b0;
        end else begin
            smartStoreWrite <= 1'b0;
            if (!smartLoaded) begin
                smartLoaded  <= 1'b1;
                smartEnabled <= smartStored;
            end else if (localDone && feature != ata_regs_pkg::SMART_AUTOSAVE) begin
                smartEnabled    <= feature == ata_regs_pkg::SMART_ENABLE;
                smartStoreWrite <= 1'b1;
                smartStoreValue <= feature == ata_regs_pkg::SMART_ENABLE;
            end
        end
    end

    // ======================================================================
    // Command hand-off to the media core
    logic otherCommandWrite;

    assign otherCommandWrite = writePulse && !coreStatus.busy && !softReset
                               && syncSecond.address == ata_regs_pkg::OFFSET_STATUS
                               && syncSecond.data != SMART_COMMAND_CODE;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            commandStart <= 1'b0;
            commandCode  <= '0;
            featureCode  <= '0;
        end else begin
            commandStart <= forwardSmart || otherCommandWrite;
            if (forwardSmart || otherCommandWrite) begin
                commandCode <= syncSecond.data;
                featureCode <= feature;
            end
        end
    end

    // ======================================================================
    // Error register, error flag and interrupt
    logic [7:0] errorCause;
    logic       errorFlag;
    logic       interruptPending;
    logic       completion;
    logic       statusRead;

    assign completion = localDone || localAbort || commandDone;
    assign statusRead = readPulse && syncSecond.address == ata_regs_pkg::OFFSET_STATUS;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            errorCause <= ata_regs_pkg::ERROR_RESET;
            errorFlag  <= 1'b0;
        end else if (softReset) begin
            errorCause <= ata_regs_pkg::ERROR_RESET;
            errorFlag  <= 1'b0;
        end else if (localAbort) begin
            errorCause <= ata_regs_pkg::ERROR_ABORT;
            errorFlag  <= 1'b1;
        end else if (localDone || (commandDone && !commandFailed)) begin
            errorCause <= ata_regs_pkg::ERROR_RESET;
            errorFlag  <= 1'b0;
        end else if (commandDone) begin
            errorCause <= commandErrorCode;
            errorFlag  <= 1'b1;
        end
    end

    // Set wins over the clearing status read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            interruptPending <= 1'b0;
        end else if (softReset) begin
            interruptPending <= 1'b0;
        end else if (completion && !interruptEnableN) begin
            interruptPending <= 1'b1;
        end else if (statusRead) begin
            interruptPending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            interruptRequest <= 1'b0;
        end else begin
            interruptRequest <= interruptPending && !interruptEnableN;
        end
    end

    // ======================================================================
    // Read-back values
    logic [7:0] statusByte;
    logic [7:0] driveAddress;
    logic       readyFlag;
    logic       driveSelect;

    assign readyFlag   = coreStatus.ready && smartLoaded && !softReset;
    assign driveSelect = driveHead[ata_regs_pkg::DRIVE_HEAD_DRV_BIT];

    // Busy overrides: remaining bits are don't-care for the host
    assign statusByte = {coreStatus.busy || softReset,
                         readyFlag,
                         coreStatus.writeFault,
                         readyFlag,
                         coreStatus.transferRequest,
                         coreStatus.correctedError,
                         1'b0,
                         errorFlag};

    // Bit 7 left low; host is not expected to use this location
    assign driveAddress = {1'b0,
                           !coreStatus.writeInProgress,
                           ~driveHead[3:0],
                           !(coreStatus.drive1Active && driveSelect),
                           !(coreStatus.drive0Active && !driveSelect)};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hostDataOut <= '0;
            hostDataOe  <= 1'b0;
        end else begin
            hostDataOe <= syncSecond.readStrobe;
            if (syncSecond.address == ata_regs_pkg::OFFSET_STATUS
                || syncSecond.address == ata_regs_pkg::OFFSET_ALT_CONTROL) begin
                hostDataOut <= statusByte;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_DRIVE_ADDRESS) begin
                hostDataOut <= driveAddress;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_ERROR_FEATURE) begin
                hostDataOut <= errorCause;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_SECTOR_COUNT) begin
                hostDataOut <= sectorCount;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_SECTOR_NUMBER) begin
                hostDataOut <= sectorNumber;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_CYL_LOW) begin
                hostDataOut <= cylLow;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_CYL_HIGH) begin
                hostDataOut <= cylHigh;
            end else if (syncSecond.address == ata_regs_pkg::OFFSET_DRIVE_HEAD) begin
                hostDataOut <= driveHead;
            end else begin
                hostDataOut <= '0;
            end
        end
    end

endmodule

`default_nettype wire

// File: ata_status_control_smart_props.sv
/*
 * Checker for the status, control and drive address ports.
 * Assumes the host holds address steady through each strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module ata_status_control_smart_props (
    // Clock and reset
    input wire logic                         ref_clk,
    input wire logic                         nrst,
    // Host side
    input wire ata_regs_pkg::hostBus_type    hostBus,
    input wire logic [7:0]                   hostDataOut,
    input wire logic                         hostDataOe,
    input wire logic                         interruptRequest,
    // Core side
    input wire ata_regs_pkg::coreStatus_type coreStatus,
    input wire logic                         commandDone,
    input wire logic                         softReset,
    input wire logic                         smartEnabled,
    input wire logic                         smartStoreWrite,
    input wire logic                         smartStoreValue
);
    logic [3:0] a1, a2, a3;
    logic       held;
    logic       rdSt;
    logic       rdF;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Address history, so read data is judged only when settled
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            a1 <= 4'h0;
            a2 <= 4'h0;
            a3 <= 4'h0;
        end else begin
            a1 <= hostBus.address;
            a2 <= a1;
            a3 <= a2;
        end
    end
    assign held = hostDataOe && hostBus.address == a3 && a1 == a3 && a2 == a3;
    assign rdSt = held && (a3 == 4'h7 || a3 == 4'he);
    assign rdF = held && a3 == 4'hf;

    // ==========================================================
    // Properties
    idx_zero_a: assert property (rdSt |-> !hostDataOut[1])
        else $error("index bit set");
    seek_ready_a: assert property (rdSt |-> hostDataOut[4] == hostDataOut[6])
        else $error("seek flag differs from ready");
    fault_bit_a: assert property (rdSt && $stable(coreStatus.writeFault)
        |-> hostDataOut[5] == $past(coreStatus.writeFault)) else $error("write fault bit wrong");
    soft_busy_a: assert property (rdSt && softReset && $past(softReset)
        |-> hostDataOut[7] && !hostDataOut[6]) else $error("soft reset status wrong");
    write_prog_a: assert property (rdF && $stable(coreStatus.writeInProgress)
        |-> hostDataOut[6] == !$past(coreStatus.writeInProgress)) else $error("write bit wrong");
    addr_top_a: assert property (rdF |-> !hostDataOut[7])
        else $error("drive address bit 7 set");
    irq_clear_a: assert property ($rose(hostDataOe) && hostBus.readStrobe
        && hostBus.address == 4'h7 && !commandDone |-> ##2 !interruptRequest)
        else $error("status read kept interrupt");
    irq_keep_a: assert property ($rose(hostDataOe) && hostBus.readStrobe
        && hostBus.address == 4'he && interruptRequest |-> ##2 interruptRequest)
        else $error("alternate read cleared interrupt");
    soft_irq_a: assert property (softReset && $past(softReset, 2) |-> !interruptRequest)
        else $error("interrupt during soft reset");
    store_val_a: assert property (smartStoreWrite
        |-> ##[0:1] smartEnabled == smartStoreValue) else $error("stored state differs");
endmodule

bind ata_status_control_smart ata_status_control_smart_props u_props (
    .ref_clk(ref_clk), .nrst(nrst), .hostBus(hostBus), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .interruptRequest(interruptRequest), .coreStatus(coreStatus),
    .commandDone(commandDone), .softReset(softReset), .smartEnabled(smartEnabled),
    .smartStoreWrite(smartStoreWrite), .smartStoreValue(smartStoreValue)
);

`default_nettype wire

// File: host_model.sv
/*
 * Host controller model: 8-bit task-file reads and writes.
 * Assumes calls start just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // Clock
    input wire logic                        ref_clk,
    // Task-file pins
    output var ata_regs_pkg::hostBus_type   hostBus,
    input wire logic [7:0]                  hostDataOut
);
    logic [7:0] lastRead;

    initial hostBus = '0;

    // ==========================================================
    // One access: strobe 5 cycles high, 4 low
    // Feature codes travel as writes to offset 1
    task automatic access(input logic wr, input logic [3:0] addr, input logic [7:0] val);
        hostBus.address = addr;
        hostBus.data = val;
        hostBus.writeStrobe = wr;
        hostBus.readStrobe = !wr;
        repeat (5) @(posedge ref_clk);
        lastRead = hostDataOut;
        #1;
        hostBus.writeStrobe = 1'b0;
        hostBus.readStrobe = 1'b0;
        // Released data no longer shows the old byte
        hostBus.data = ~val;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
endmodule

`default_nettype wire

// File: testbench.sv
/*
 * Self-checking bench for the status, control and SMART block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [7:0] SMART_CMD = 8'hb0;
    logic                         ref_clk;
    logic                         nrst;
    ata_regs_pkg::hostBus_type    hostBus;
    ata_regs_pkg::coreStatus_type coreStatus;
    logic                         commandDone, commandFailed, smartStored, startSeen;
    logic                         hostDataOe, interruptRequest, commandStart, softReset;
    logic                         smartEnabled, smartStoreWrite, smartStoreValue;
    logic [7:0]                   hostDataOut, commandCode, featureCode, commandErrorCode;
    logic [7:0]                   r, h, s, seenFeature, seenCode;
    logic [33:0]                  t;
    logic [33:0]                  smartTab [11];
    int                           err_count, check_count, cycles, i;

    ata_status_control_smart #(.SMART_COMMAND_CODE(SMART_CMD)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .hostBus(hostBus), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .interruptRequest(interruptRequest), .coreStatus(coreStatus),
        .commandDone(commandDone), .commandFailed(commandFailed),
        .commandErrorCode(commandErrorCode), .commandStart(commandStart),
        .commandCode(commandCode), .featureCode(featureCode), .softReset(softReset),
        .smartStored(smartStored), .smartEnabled(smartEnabled),
        .smartStoreWrite(smartStoreWrite), .smartStoreValue(smartStoreValue)
    );
    host_model u_host (.ref_clk(ref_clk), .hostBus(hostBus), .hostDataOut(hostDataOut));

    // ==========================================================
    // Clock, timeout and start monitor
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (commandStart === 1'b1) begin
            startSeen <= 1'b1;
            seenFeature <= featureCode;
            seenCode <= commandCode;
        end
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end

    // ==========================================================
    // Expectations and helpers
    function automatic logic [7:0] expStatus(ata_regs_pkg::coreStatus_type c);
        return {c.busy, c.ready, c.writeFault, c.ready, c.transferRequest, c.correctedError, 2'h0};
    endfunction
    function automatic logic [7:0] expAddr(ata_regs_pkg::coreStatus_type c, logic [7:0] hd);
        return {1'b0, !c.writeInProgress, ~hd[3:0], !(c.drive1Active && hd[4]),
                !(c.drive0Active && !hd[4])};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        u_host.access(1'b0, a, 8'h00);
        v = u_host.lastRead;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        u_host.access(1'b1, a, v);
    endtask
    task automatic finishCmd(input logic failed, input logic [7:0] code);
        commandFailed = failed;
        commandErrorCode = code;
        commandDone = 1'b1;
        @(posedge ref_clk);
        #1;
        commandDone = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        coreStatus = '0;
        {commandDone, commandFailed, smartStored, startSeen} = 4'h0;
        commandErrorCode = 8'h00;
        nrst = 1'b0;
        smartTab = '{{8'hd8, 8'h4f, 8'hc2, 8'h00, 2'h2}, {8'hd9, 8'h4f, 8'hc3, 8'h00, 2'h3},
                     {8'hd9, 8'h4f, 8'hc2, 8'h00, 2'h0}, {8'hd2, 8'h4f, 8'hc2, 8'h00, 2'h1},
                     {8'hd0, 8'h4f, 8'hc2, 8'h00, 2'h1}, {8'hd8, 8'h4f, 8'hc2, 8'h00, 2'h2},
                     {8'hd2, 8'h4f, 8'hc2, 8'hf1, 2'h2}, {8'hd2, 8'h4f, 8'hc2, 8'h00, 2'h2},
                     {8'hd2, 8'h4f, 8'hc2, 8'h05, 2'h3}, {8'h77, 8'h4f, 8'hc2, 8'h00, 2'h3},
                     {8'hd8, 8'h4e, 8'hc2, 8'h00, 2'h3}};
        void'($urandom(32'h603a));
        repeat (12) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("smart after reset", 8'h00, {7'h00, smartEnabled});
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            coreStatus = r;
            rd(ata_regs_pkg::OFFSET_STATUS, s);
            if (coreStatus.busy) chk("busy", 8'h80, s & 8'h80);
            else chk("status", expStatus(coreStatus), s);
            rd(ata_regs_pkg::OFFSET_ALT_CONTROL, s);
            if (!coreStatus.busy) chk("alt status", expStatus(coreStatus), s);
        end
        $display("test status done");
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            h = $urandom;
            coreStatus = r & 8'h7f;
            wr(ata_regs_pkg::OFFSET_DRIVE_HEAD, h | 8'ha0);
            rd(ata_regs_pkg::OFFSET_DRIVE_ADDRESS, s);
            chk("drive address", expAddr(coreStatus, h), s);
        end
        $display("test drive address done");
        coreStatus = 8'h40;
        wr(ata_regs_pkg::OFFSET_ALT_CONTROL, 8'h09);
        finishCmd(1'b0, 8'h00);
        chk("irq on", 8'h01, {7'h00, interruptRequest});
        rd(ata_regs_pkg::OFFSET_ALT_CONTROL, s);
        chk("irq after alt", 8'h01, {7'h00, interruptRequest});
        rd(ata_regs_pkg::OFFSET_STATUS, s);
        chk("irq after status", 8'h00, {7'h00, interruptRequest});
        wr(ata_regs_pkg::OFFSET_ALT_CONTROL, 8'hf2);
        finishCmd(1'b0, 8'h00);
        chk("irq masked", 8'h00, {7'h00, interruptRequest});
        wr(ata_regs_pkg::OFFSET_ALT_CONTROL, 8'h04);
        chk("soft reset on", 8'h01, {7'h00, softReset});
        rd(ata_regs_pkg::OFFSET_STATUS, s);
        chk("soft status", 8'h80, s & 8'hc0);
        wr(ata_regs_pkg::OFFSET_ALT_CONTROL, 8'h00);
        rd(ata_regs_pkg::OFFSET_STATUS, s);
        chk("soft released", 8'h50, s & 8'hd0);
        $display("test control done");
        for (i = 0; i < 11; i++) begin
            t = smartTab[i];
            wr(ata_regs_pkg::OFFSET_CYL_LOW, t[25:18]);
            wr(ata_regs_pkg::OFFSET_CYL_HIGH, t[17:10]);
            wr(ata_regs_pkg::OFFSET_SECTOR_COUNT, t[9:2]);
            wr(ata_regs_pkg::OFFSET_ERROR_FEATURE, t[33:26]);
            wr(ata_regs_pkg::OFFSET_STATUS, SMART_CMD);
            rd(ata_regs_pkg::OFFSET_STATUS, s);
            chk("error flag", {7'h00, t[0]}, s & 8'h01);
            chk("smart state", {7'h00, t[1]}, {7'h00, smartEnabled});
            rd(ata_regs_pkg::OFFSET_ERROR_FEATURE, s);
            if (t[0]) chk("abort code", ata_regs_pkg::ERROR_ABORT, s);
        end
        wr(ata_regs_pkg::OFFSET_ERROR_FEATURE, ata_regs_pkg::SMART_READ_THRESH);
        wr(ata_regs_pkg::OFFSET_STATUS, SMART_CMD);
        chk("forwarded", ata_regs_pkg::SMART_READ_THRESH, startSeen ? seenFeature : 8'h00);
        chk("forwarded code", SMART_CMD, startSeen ? seenCode : 8'h00);
        finishCmd(1'b1, 8'h04);
        rd(ata_regs_pkg::OFFSET_ERROR_FEATURE, s);
        chk("core error", 8'h04, s);
        wr(ata_regs_pkg::OFFSET_STATUS, 8'h20);
        chk("command code", 8'h20, seenCode);
        coreStatus = 8'hc0;
        wr(ata_regs_pkg::OFFSET_CYL_LOW, 8'h11);
        coreStatus = 8'h40;
        rd(ata_regs_pkg::OFFSET_CYL_LOW, s);
        chk("busy refused", 8'h4e, s);
        $display("test smart done");
        // Second reset with the store holding enabled
        nrst = 1'b0;
        smartStored = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("smart reloaded", 8'h01, {7'h00, smartEnabled});
        rd(ata_regs_pkg::OFFSET_STATUS, s);
        chk("status after reset", 8'h50, s);
        $display("test reset done");
        stop_test();
    end
endmodule

`default_nettype wire
